/* File: hw/frcr_top.sv */
// How it works
// - Register picks read mode and burst timing.
// - Identifier read at offset 05 returns register.
// - Bit 15: one asynchronous, zero synchronous burst.
// - Latency bits 13:11, codes 2-7, reset 111.
// - Bit 10 sets wait output asserted level.
// - Bit 9 holds words one or two clocks.
// - Setup 60 then 03 loads address; else error.
// - After configure, reads return array data.
// - Asynchronous page mode after reset.
// - Latency counts clocks before first burst word.
`timescale 1ns/1ns
`default_nettype none

module frcr_top
  import frcr_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic chip_enable_n,
  input wire logic output_enable_n,
  input wire logic write_enable_n,
  input wire logic address_valid_strobe_n,
  input wire logic [15:0] bus_addr,
  input wire logic [15:0] bus_dq_in,
  input wire logic [15:0] array_rdata,
  output logic [15:0] array_addr,
  output logic [15:0] bus_dq_out,
  output logic bus_dq_oe,
  output logic wait_out,
  output logic wait_oe,
  output logic [15:0] read_config_reg,
  output logic status_bit_four,
  output logic status_bit_five
);

  logic [3:0] strobe_s;
  logic [31:0] bus_s;
  logic ce_low;
  logic oe_low;
  logic we_high;
  logic adv_low;
  logic [15:0] addr_s;
  logic [15:0] data_s;

  // Every pin passes two flops before any logic looks at it.
  frcr_sync #(.WIDTH(4), .RST_VAL(FRCR_STROBE_IDLE)) u_sync_strobe (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in({chip_enable_n, output_enable_n, write_enable_n, address_valid_strobe_n}),
    .sync_out(strobe_s)
  );
  frcr_sync #(.WIDTH(32), .RST_VAL(FRCR_BUS_IDLE)) u_sync_bus (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in({bus_addr, bus_dq_in}),
    .sync_out(bus_s)
  );

  assign ce_low = ~strobe_s[3];
  assign oe_low = ~strobe_s[2];
  assign we_high = strobe_s[1];
  assign adv_low = ~strobe_s[0];
  assign addr_s = bus_s[31:16];
  assign data_s = bus_s[15:0];

  // Command interface state and the register itself.
  frcr_state_type state_q, state_d;
  logic [15:0] rcfg_q, rcfg_d;
  logic sr4_q, sr4_d;
  logic sr5_q, sr5_d;
  logic we_prev_q, we_prev_d;
  logic write_done;
  logic [7:0] cmd;

  // A write is taken when the synchronised write strobe rises with chip enable low.
  assign write_done = we_high & ~we_prev_q & ce_low;
  assign cmd = data_s[7:0];

  always_comb begin
    state_d = state_q;
    rcfg_d = rcfg_q;
    sr4_d = sr4_q;
    sr5_d = sr5_q;
    we_prev_d = we_high;
    if (write_done) begin
      case (state_q)
        FRCR_ST_CFG_SETUP: begin
          if (cmd == FRCR_CMD_CFG_CONFIRM) begin
            rcfg_d = addr_s;
          end else begin
            sr4_d = 1'b1;
            sr5_d = 1'b1;
          end
          state_d = FRCR_ST_READ_ARRAY;
        end
        default: begin
          if (cmd == FRCR_CMD_CFG_SETUP) begin
            state_d = FRCR_ST_CFG_SETUP;
          end else if (cmd == FRCR_CMD_READ_ID) begin
            state_d = FRCR_ST_READ_ID;
          end else if (cmd == FRCR_CMD_READ_ARRAY) begin
            state_d = FRCR_ST_READ_ARRAY;
          end else if (cmd == FRCR_CMD_CLEAR_STATUS) begin
            // Clear cannot meet a set: errors only arise in the setup state.
            sr4_d = 1'b0;
            sr5_d = 1'b0;
          end
        end
      endcase
    end
  end

  // The register never remembers anything across reset.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= FRCR_ST_READ_ARRAY;
      rcfg_q <= FRCR_RCFG_RESET;
      sr4_q <= 1'b0;
      sr5_q <= 1'b0;
      we_prev_q <= 1'b1;
    end else begin
      state_q <= state_d;
      rcfg_q <= rcfg_d;
      sr4_q <= sr4_d;
      sr5_q <= sr5_d;
      we_prev_q <= we_prev_d;
    end
  end

  // Burst timing fields decoded from the register.
  logic sync_mode;
  logic [2:0] latency;
  logic wait_pol;
  logic hold_two;
  assign sync_mode = ~rcfg_q[FRCR_BIT_READ_MODE];
  assign latency = rcfg_q[FRCR_LAT_HI:FRCR_LAT_LO];
  assign wait_pol = rcfg_q[FRCR_BIT_WAIT_POL];
  assign hold_two = rcfg_q[FRCR_BIT_DATA_HOLD];

  // Burst sequencing state.
  logic active_q, active_d;
  logic valid_q, valid_d;
  logic [2:0] lat_cnt_q, lat_cnt_d;
  logic hold_q, hold_d;
  logic [15:0] aaddr_q, aaddr_d;
  logic start;

  // A burst starts on the first edge that sees the address strobe low.
  assign start = sync_mode & ce_low & adv_low & ~active_q;

  always_comb begin
    active_d = active_q;
    valid_d = valid_q;
    lat_cnt_d = lat_cnt_q;
    hold_d = hold_q;
    aaddr_d = aaddr_q;
    if (!ce_low || !sync_mode) begin
      active_d = 1'b0;
      valid_d = 1'b0;
      aaddr_d = addr_s;
    end else if (start) begin
      active_d = 1'b1;
      valid_d = 1'b0;
      lat_cnt_d = latency;
      hold_d = 1'b0;
      aaddr_d = addr_s;
    end else if (active_q && !valid_q) begin
      lat_cnt_d = lat_cnt_q - 3'd1;
      valid_d = (lat_cnt_q == 3'd1);
    end else if (valid_q) begin
      // With a two-clock hold the address steps on every other edge.
      if (hold_two && !hold_q) begin
        hold_d = 1'b1;
      end else begin
        hold_d = 1'b0;
        aaddr_d = aaddr_q + 16'd1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      active_q <= 1'b0;
      valid_q <= 1'b0;
      lat_cnt_q <= 3'h0;
      hold_q <= 1'b0;
      aaddr_q <= 16'h0000;
    end else begin
      active_q <= active_d;
      valid_q <= valid_d;
      lat_cnt_q <= lat_cnt_d;
      hold_q <= hold_d;
      aaddr_q <= aaddr_d;
    end
  end

  // Pin-facing outputs, all registered.
  logic [15:0] dq_q, dq_d;
  logic dq_oe_q, dq_oe_d;
  logic wait_q, wait_d;
  logic wait_oe_q, wait_oe_d;
  logic id_hit;

  assign id_hit = (state_q == FRCR_ST_READ_ID) && (addr_s[7:0] == FRCR_ID_OFFSET_RCFG);

  always_comb begin
    dq_oe_d = ce_low & oe_low;
    wait_oe_d = ce_low & oe_low;
    dq_d = (id_hit) ? rcfg_q : array_rdata;
    // Wait is asserted only while a synchronous burst has no data yet.
    wait_d = (active_q & ~valid_q) ? wait_pol : ~wait_pol;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dq_q <= 16'h0000;
      dq_oe_q <= 1'b0;
      wait_q <= 1'b0;
      wait_oe_q <= 1'b0;
    end else begin
      dq_q <= dq_d;
      dq_oe_q <= dq_oe_d;
      wait_q <= wait_d;
      wait_oe_q <= wait_oe_d;
    end
  end

  assign bus_dq_out = dq_q;
  assign bus_dq_oe = dq_oe_q;
  assign wait_out = wait_q;
  assign wait_oe = wait_oe_q;
  assign array_addr = aaddr_q;
  assign read_config_reg = rcfg_q;
  assign status_bit_four = sr4_q;
  assign status_bit_five = sr5_q;

  // Helper: cycles since the burst started, for the latency check.
  logic [3:0] elapsed_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      elapsed_q <= 4'h0;
    end else begin
      elapsed_q <= start ? 4'h0 : elapsed_q + 4'h1;
    end
  end

  chk_cfg_load: assert property (@(posedge core_clk) disable iff (!rst_n)
    (write_done && state_q == FRCR_ST_CFG_SETUP && cmd == FRCR_CMD_CFG_CONFIRM)
    |=> (rcfg_q == $past(addr_s)) && (state_q == FRCR_ST_READ_ARRAY))
    else $error("Confirm did not load the address into the register.");

  chk_seq_error: assert property (@(posedge core_clk) disable iff (!rst_n)
    (write_done && state_q == FRCR_ST_CFG_SETUP && cmd != FRCR_CMD_CFG_CONFIRM)
    |=> sr4_q && sr5_q && $stable(rcfg_q))
    else $error("Bad second command did not flag a sequence error.");

  chk_back_array: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_q == FRCR_ST_CFG_SETUP && write_done) |=> state_q == FRCR_ST_READ_ARRAY)
    else $error("Configure sequence did not return to array read.");

  chk_id_read: assert property (@(posedge core_clk) disable iff (!rst_n)
    id_hit && ce_low && oe_low |=> bus_dq_oe && bus_dq_out == $past(rcfg_q))
    else $error("Identifier offset did not return the register.");

  chk_reset_value: assert property (@(posedge core_clk)
    $rose(rst_n) |-> rcfg_q == FRCR_RCFG_RESET && !sync_mode && latency == 3'h7)
    else $error("Register left reset without its default value.");

  chk_only_confirm: assert property (@(posedge core_clk) disable iff (!rst_n)
    !(write_done && state_q == FRCR_ST_CFG_SETUP) |=> $stable(rcfg_q))
    else $error("Register changed outside the configure sequence.");

  chk_async_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
    !sync_mode [*2] |-> !active_q ##1 wait_out == ~$past(wait_pol))
    else $error("Asynchronous mode showed an asserted wait.");

  chk_latency_cnt: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(valid_q) && $past(active_q) && $stable(rcfg_q) |-> elapsed_q == {1'b0, latency})
    else $error("First word not after the programmed latency.");

  chk_wait_level: assert property (@(posedge core_clk) disable iff (!rst_n)
    active_q && !valid_q ##1 active_q && $stable(rcfg_q) |-> wait_out == wait_pol)
    else $error("Wait output not at the programmed asserted level.");

  chk_data_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    valid_q && hold_two && !hold_q && ce_low && sync_mode |=> $stable(aaddr_q))
    else $error("Two-clock hold advanced the word too early.");

endmodule // frcr_top

`default_nettype wire

/* File: hw/frcr_pkg.sv */
package frcr_pkg;

  // Register location in identifier space and its layout.
  localparam logic [7:0] FRCR_ID_OFFSET_RCFG = 8'h05;
  localparam int FRCR_BIT_READ_MODE = 15;
  localparam int FRCR_BIT_RESERVED = 14;
  localparam int FRCR_LAT_HI = 13;
  localparam int FRCR_LAT_LO = 11;
  localparam int FRCR_BIT_WAIT_POL = 10;
  localparam int FRCR_BIT_DATA_HOLD = 9;

  // Value after reset: asynchronous page mode, latency 7, wait active high, two-clock hold.
  localparam logic [15:0] FRCR_RCFG_RESET = 16'hBFCF;
  localparam logic [2:0] FRCR_LAT_MIN = 3'h2;

  // Command codes seen on the low data byte of a bus write.
  localparam logic [7:0] FRCR_CMD_CFG_SETUP = 8'h60;
  localparam logic [7:0] FRCR_CMD_CFG_CONFIRM = 8'h03;
  localparam logic [7:0] FRCR_CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] FRCR_CMD_READ_ID = 8'h90;
  localparam logic [7:0] FRCR_CMD_CLEAR_STATUS = 8'h50;

  // Reset values of the pin synchronisers: strobes idle high, buses idle low.
  localparam logic [3:0] FRCR_STROBE_IDLE = 4'hF;
  localparam logic [31:0] FRCR_BUS_IDLE = 32'h0000_0000;

  // Command interface states.
  typedef enum logic [1:0] {
    FRCR_ST_READ_ARRAY = 2'b00,
    FRCR_ST_READ_ID = 2'b01,
    FRCR_ST_CFG_SETUP = 2'b10
  } frcr_state_type;

endpackage : frcr_pkg

/* File: hw/frcr_sync.sv */
`timescale 1ns/1ns
`default_nettype none

// Two flip-flop synchroniser, one stage pair per bit.
module frcr_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      logic meta_q;
      logic sync_q;
      // The first stage feeds only the second stage.
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_q <= RST_VAL[gi];
          sync_q <= RST_VAL[gi];
        end else begin
          meta_q <= async_in[gi];
          sync_q <= meta_q;
        end
      end
      assign sync_out[gi] = sync_q;
    end
  endgenerate

endmodule // frcr_sync

`default_nettype wire

/* File: hw/frcr_unused_placeholder_none.sv */
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

/* File: testbench/frcr_host_model.sv */
`timescale 1ns/1ns
`default_nettype none

// Host controller on the flash pins; strobes change just after a clock edge.
module frcr_host_model
  import frcr_pkg::*;
(
  input wire logic core_clk,
  input wire logic [15:0] bus_dq_out,
  input wire logic wait_out,
  input wire logic wait_oe,
  input wire logic [15:0] array_addr,
  output logic chip_enable_n,
  output logic output_enable_n,
  output logic write_enable_n,
  output logic address_valid_strobe_n,
  output logic [15:0] bus_addr,
  output logic [15:0] bus_dq_in
);
  // All strobes idle high from time zero.
  initial begin
    chip_enable_n = 1'b1;
    output_enable_n = 1'b1;
    write_enable_n = 1'b1;
    address_valid_strobe_n = 1'b1;
    bus_addr = 16'h0000;
    bus_dq_in = 16'h0000;
  end

  // One bus write; data is inverted once its hold has run out.
  task automatic cmd(input logic [15:0] a, input logic [7:0] c);
    @(posedge core_clk);
    chip_enable_n <= 1'b0;
    write_enable_n <= 1'b0;
    bus_addr <= a;
    bus_dq_in <= {8'h00, c};
    repeat (3) @(posedge core_clk);
    write_enable_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    chip_enable_n <= 1'b1;
    bus_dq_in <= ~{8'h00, c};
  endtask

  // Configure pair with reserved bit 14 cleared.
  task automatic configure(input logic [15:0] v);
    cmd(16'h0000, FRCR_CMD_CFG_SETUP);
    cmd(v & 16'hBFFF, FRCR_CMD_CFG_CONFIRM);
  endtask

  // Word read; the pins need two edges to reach the logic and one more to the output, so wait five.
  task automatic read(input logic [15:0] a, output logic [15:0] d);
    @(posedge core_clk);
    chip_enable_n <= 1'b0;
    output_enable_n <= 1'b0;
    bus_addr <= a;
    repeat (5) @(posedge core_clk);
    d = bus_dq_out;
    chip_enable_n <= 1'b1;
    output_enable_n <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask

  // Burst with the address strobe held low; counts wait cycles and address steps.
  task automatic burst(input logic pol, output int waits, output logic [15:0] steps);
    logic [15:0] a0;
    waits = 0;
    @(posedge core_clk);
    chip_enable_n <= 1'b0;
    output_enable_n <= 1'b0;
    address_valid_strobe_n <= 1'b0;
    repeat (20) begin
      @(posedge core_clk);
      if (wait_oe === 1'b1 && wait_out === pol) waits++;
    end
    a0 = array_addr;
    repeat (8) @(posedge core_clk);
    steps = array_addr - a0;
    chip_enable_n <= 1'b1;
    output_enable_n <= 1'b1;
    address_valid_strobe_n <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask
endmodule // frcr_host_model

`default_nettype wire

/* File: testbench/test_flash_read_config_register.sv */
`timescale 1ns/1ns
`default_nettype none

module test_flash_read_config_register
  import frcr_pkg::*;
;
  logic core_clk, rst_n, ce_n, oe_n, we_n, adv_n, dq_oe, wt, wt_oe, st4, st5;
  logic [15:0] addr, dq_in, array_rdata, array_addr, dq_out, cfg, d, v, steps;
  logic [31:0] seed;
  int compares = 0;
  int miscompares = 0;
  int waits;

  // Free running 250 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  frcr_top i_frcr_top (.core_clk(core_clk), .rst_n(rst_n), .chip_enable_n(ce_n),
    .output_enable_n(oe_n), .write_enable_n(we_n), .address_valid_strobe_n(adv_n),
    .bus_addr(addr), .bus_dq_in(dq_in), .array_rdata(array_rdata),
    .array_addr(array_addr), .bus_dq_out(dq_out), .bus_dq_oe(dq_oe), .wait_out(wt),
    .wait_oe(wt_oe), .read_config_reg(cfg), .status_bit_four(st4), .status_bit_five(st5));

  frcr_host_model i_frcr_host_model (.core_clk(core_clk), .bus_dq_out(dq_out),
    .wait_out(wt), .wait_oe(wt_oe), .array_addr(array_addr), .chip_enable_n(ce_n),
    .output_enable_n(oe_n), .write_enable_n(we_n), .address_valid_strobe_n(adv_n),
    .bus_addr(addr), .bus_dq_in(dq_in));

  // Xorshift keeps the random stream repeatable.
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // Legal burst setting: synchronous mode, given latency and wait level.
  function automatic logic [15:0] legal(input logic [15:0] r, input int lat, input logic pol);
    return {1'b0, 1'b0, 3'(lat), pol, r[9:0]};
  endfunction

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (compares > 0 && miscompares == 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Bounded run; a hang counts as a mismatch.
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    close_out();
  end

  initial begin
    rst_n = 1'b0;
    array_rdata = 16'h0000;
    seed = 32'h0000_931a;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    check("reset fields", 16'hBE00, cfg & 16'hFE00);
    check("idle pins", 16'h0000, {13'h0, dq_oe, st4, st5});
    i_frcr_host_model.burst(1'b1, waits, steps);
    check("async waits", 16'h0000, 16'(waits));
    i_frcr_host_model.cmd(16'h0000, FRCR_CMD_READ_ID);
    i_frcr_host_model.read(16'h0005, d);
    check("id reset", 16'hBE00, d & 16'hFE00);
    // Every legal latency code, both wait levels, random hold and low bits.
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      v = legal(seed[15:0], i + 2, i[0]);
      i_frcr_host_model.configure(v);
      check("config", v, cfg);
      array_rdata <= seed[31:16];
      i_frcr_host_model.read(16'h0005, d);
      check("array after config", seed[31:16], d);
      i_frcr_host_model.cmd(16'h0000, FRCR_CMD_READ_ID);
      i_frcr_host_model.read(16'h0005, d);
      check("id read", v, d);
      i_frcr_host_model.burst(v[10], waits, steps);
      check("wait cycles", 16'(i + 2), 16'(waits));
      check("addr steps", v[9] ? 16'h0004 : 16'h0008, steps);
    end
    // Setup followed by a foreign code flags an error and keeps the value.
    i_frcr_host_model.cmd(16'h0000, FRCR_CMD_CFG_SETUP);
    i_frcr_host_model.cmd(16'h1234, FRCR_CMD_READ_ID);
    check("seq error", 16'h0003, {14'h0, st4, st5});
    check("kept", v, cfg);
    i_frcr_host_model.cmd(16'h0000, FRCR_CMD_CLEAR_STATUS);
    check("cleared", 16'h0000, {14'h0, st4, st5});
    // Reset in mid run restores the defaults.
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    check("reset again", 16'hBE00, cfg & 16'hFE00);
    close_out();
  end
endmodule // test_flash_read_config_register

`default_nettype wire
